// *** shared/loopback_and_error_rate_tester_test_map.vh ***
// Register map, field positions, reset values and tester constants
// for the loopback and bit error rate test block. Definitions only.
`ifndef LOOPBACK_AND_ERROR_RATE_TESTER_TEST_MAP_VH
`define LOOPBACK_AND_ERROR_RATE_TESTER_TEST_MAP_VH

`define A_CTRL 8'h00
`define A_CMD 8'h04
`define A_STATUS 8'h08
`define A_SYNC_LOSS 8'h0c
`define A_BIT_ERR 8'h10
`define A_RX_BITS 8'h14
`define A_ERR_SEC 8'h18
`define A_ELAPSED 8'h1c
`define A_EFS_PCT 8'h20
`define A_RATIO 8'h24

`define F_TX_PAT 0
`define F_RX_PAT 2
`define F_DIR 4
`define F_TER_LOOP 5
`define F_SAT_LOOP 6
`define F_IF_LOOP 7
`define F_INJECT 0
`define F_RESTART 1

`define CTRL_RESET 8'h00
`define NV_MASK 8'h9f
`define PAT_OFF 2'h0
`define PAT_SHORT 2'h1
`define PAT_LONG 2'h2
`define SEED 23'h7fffff

`define SYNC_RUN 6'h20
`define WIN_LAST 7'h7f
`define LOSS_LIMIT 8'h10

`define EFS_FULL 14'h2710
`define MANT_SCALE 14'h03e8
`define TEN 14'h000a
`define STEP_LAST 4'hd

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** logic/loopback_and_error_rate_tester_test.v ***
// Loopback points and bit error rate tester with AXI4-Lite registers.
// Assumes bit streams marked by one-cycle valid strobes on aclk and a
// one-cycle second_tick; nv_cfg holds stored settings at reset release.
`timescale 1ns/1ps
`include "loopback_and_error_rate_tester_test_map.vh"

module loopback_and_error_rate_tester_test (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ter_in_data,
	input wire ter_in_valid,
	output reg ter_out_data,
	output reg ter_out_valid,
	output reg mod_data,
	output reg mod_valid,
	input wire dem_data,
	input wire dem_valid,
	input wire second_tick,
	input wire [7:0] nv_cfg,
	output reg [7:0] persist_cfg,
	output reg mod_timing_from_demod,
	output reg if_loop_enable
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_NORM = 4'b0010;
	localparam [3:0] ST_DIV = 4'b0100;
	localparam [3:0] ST_EFS = 4'b1000;

	function pat_on;
		input [1:0] p;
		begin
			pat_on = (p == `PAT_SHORT) || (p == `PAT_LONG);
		end
	endfunction

	// Feedback bit of the selected maximal-length sequence
	function prbs_fb;
		input [22:0] s;
		input [1:0] p;
		begin
			prbs_fb = (p == `PAT_LONG) ? (s[22] ^ s[17]) : (s[10] ^ s[8]);
		end
	endfunction

	function [47:0] mul_k;
		input [47:0] a;
		input [13:0] k;
		reg [61:0] t;
		begin
			t = a * k;
			mul_k = t[47:0];
		end
	endfunction

	reg [7:0] ctrl;
	reg restore_pending;
	reg [7:0] wa;
	reg [31:0] wd;
	reg [3:0] ws;
	reg inject_pending;
	reg [22:0] gen_state;
	reg [22:0] chk_state;
	reg synced;
	reg [5:0] run_cnt;
	reg [6:0] win_cnt;
	reg [7:0] win_err;
	reg sec_err;
	reg [1:0] rx_last;
	reg [31:0] sync_loss_count;
	reg [31:0] bit_error_count;
	reg [31:0] received_bit_count;
	reg [31:0] errored_second_count;
	reg [31:0] elapsed_second_count;
	reg [13:0] error_free_second_pct;
	reg [13:0] ratio_mant;
	reg [7:0] ratio_exp;
	reg [3:0] state;
	reg [47:0] num;
	reg [31:0] den;
	reg [7:0] pow;
	reg [47:0] rem;
	reg [47:0] dvs;
	reg [13:0] quo;
	reg [3:0] step;
	reg div_efs;
	reg [31:0] rd_mux;
	reg rd_ok;

	wire [1:0] tx_pattern_select = ctrl[`F_TX_PAT+1:`F_TX_PAT];
	wire [1:0] rx_pattern_select = ctrl[`F_RX_PAT+1:`F_RX_PAT];
	wire tester_direction_select = ctrl[`F_DIR];
	wire ter_loop = ctrl[`F_TER_LOOP];
	wire sat_loop = ctrl[`F_SAT_LOOP];
	wire if_loop = ctrl[`F_IF_LOOP];
	wire tx_on = pat_on(tx_pattern_select);
	wire rx_on = pat_on(rx_pattern_select);

	wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire cmd_wr = wr_go && (wa == `A_CMD) && ws[0];
	wire cmd_inject = cmd_wr && wd[`F_INJECT];
	wire cmd_restart = cmd_wr && wd[`F_RESTART];
	wire restart = cmd_restart || (rx_pattern_select != rx_last);

	wire rx_bit = if_loop ? mod_data : dem_data;
	wire rx_valid = if_loop ? mod_valid : dem_valid;

	// Generator runs on the bit clock of the side it feeds
	wire gen_step = tx_on && (tester_direction_select ? rx_valid :
		ter_in_valid);
	wire gen_bit = prbs_fb(gen_state, tx_pattern_select) ^
		inject_pending;

	// Checker input; data taken by the terrestrial or satellite loop never reaches it, IF-looped modulator data does
	wire chk_bit = tester_direction_select ? ter_in_data : rx_bit;
	wire chk_valid = rx_on && (tester_direction_select ?
		(ter_in_valid && !ter_loop) : (rx_valid && !sat_loop));
	wire chk_exp = prbs_fb(chk_state, rx_pattern_select);
	wire mism = chk_bit ^ chk_exp;
	wire err_now = chk_valid && synced && mism;
	wire [7:0] win_err_n = win_err + {7'h00, mism};
	wire q_bit = rem >= dvs;
	wire [13:0] quo_n = {quo[12:0], q_bit};

	// Register bus
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			wa <= 8'h00;
			wd <= 32'h00000000;
			ws <= 4'h0;
			ctrl <= `CTRL_RESET;
			restore_pending <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wa <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wd <= s_axi_wdata;
				ws <= s_axi_wstrb;
			end
			if (restore_pending) begin
				ctrl <= nv_cfg & `NV_MASK;
				restore_pending <= 1'b0;
			end else if (wr_go && wa == `A_CTRL && ws[0]) begin
				ctrl <= wd[7:0];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				case (wa)
				`A_CTRL, `A_CMD, `A_STATUS, `A_SYNC_LOSS, `A_BIT_ERR,
				`A_RX_BITS, `A_ERR_SEC, `A_ELAPSED, `A_EFS_PCT,
				`A_RATIO: s_axi_bresp <= `RESP_OKAY;
				default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	always @* begin
		rd_ok = 1'b1;
		rd_mux = 32'h00000000;
		case (s_axi_araddr)
		`A_CTRL: rd_mux = {24'h000000, ctrl};
		`A_CMD: rd_mux = 32'h00000000;
		`A_STATUS: rd_mux = {28'h0000000, inject_pending, rx_on, tx_on,
			synced};
		`A_SYNC_LOSS: rd_mux = sync_loss_count;
		`A_BIT_ERR: rd_mux = bit_error_count;
		`A_RX_BITS: rd_mux = received_bit_count;
		`A_ERR_SEC: rd_mux = errored_second_count;
		`A_ELAPSED: rd_mux = elapsed_second_count;
		`A_EFS_PCT: rd_mux = {18'h00000, error_free_second_pct};
		`A_RATIO: rd_mux = {8'h00, ratio_exp, 2'h0, ratio_mant};
		default: rd_ok = 1'b0;
		endcase
	end

	// Data routing and pattern generation
	always @(posedge aclk) begin
		if (!aresetn) begin
			mod_data <= 1'b0;
			mod_valid <= 1'b0;
			ter_out_data <= 1'b0;
			ter_out_valid <= 1'b0;
			gen_state <= `SEED;
			inject_pending <= 1'b0;
			persist_cfg <= `CTRL_RESET;
			mod_timing_from_demod <= 1'b0;
			if_loop_enable <= 1'b0;
		end else begin
			persist_cfg <= ctrl & `NV_MASK;
			mod_timing_from_demod <= sat_loop;
			if_loop_enable <= if_loop;
			if (!tx_on)
				gen_state <= `SEED;
			else if (gen_step)
				gen_state <= {gen_state[21:0],
					prbs_fb(gen_state, tx_pattern_select)};
			inject_pending <= tx_on && (cmd_inject ||
				(inject_pending && !gen_step));
			if (sat_loop) begin
				mod_data <= dem_data;
				mod_valid <= dem_valid;
			end else if (tx_on && !tester_direction_select) begin
				mod_data <= gen_bit;
				mod_valid <= ter_in_valid;
			end else if (rx_on && tester_direction_select) begin
				mod_data <= 1'b0;
				mod_valid <= 1'b0;
			end else begin
				mod_data <= ter_in_data;
				mod_valid <= ter_in_valid;
			end
			if (ter_loop) begin
				ter_out_data <= ter_in_data;
				ter_out_valid <= ter_in_valid;
			end else if (sat_loop) begin
				ter_out_data <= 1'b0;
				ter_out_valid <= 1'b0;
			end else if (tx_on && tester_direction_select) begin
				ter_out_data <= gen_bit;
				ter_out_valid <= rx_valid;
			end else if (rx_on && !tester_direction_select) begin
				ter_out_data <= 1'b0;
				ter_out_valid <= 1'b0;
			end else begin
				ter_out_data <= rx_bit;
				ter_out_valid <= rx_valid;
			end
		end
	end

	// Pattern checker and statistics
	always @(posedge aclk) begin
		if (!aresetn || restart || !rx_on) begin
			chk_state <= `SEED;
			synced <= 1'b0;
			run_cnt <= 6'h00;
			win_cnt <= 7'h00;
			win_err <= 8'h00;
			sec_err <= 1'b0;
			sync_loss_count <= 32'h00000000;
			bit_error_count <= 32'h00000000;
			received_bit_count <= 32'h00000000;
			errored_second_count <= 32'h00000000;
			elapsed_second_count <= 32'h00000000;
		end else begin
			if (chk_valid) begin
				received_bit_count <= received_bit_count + 32'h1;
				if (!synced) begin
					chk_state <= {chk_state[21:0], chk_bit};
					run_cnt <= mism ? 6'h00 : run_cnt + 6'h01;
					if (!mism && run_cnt == `SYNC_RUN - 6'h01) begin
						synced <= 1'b1;
						win_cnt <= 7'h00;
						win_err <= 8'h00;
					end
				end else begin
					chk_state <= {chk_state[21:0], chk_exp};
					if (mism)
						bit_error_count <= bit_error_count + 32'h1;
					if (win_err_n > `LOSS_LIMIT) begin
						synced <= 1'b0;
						run_cnt <= 6'h00;
						sync_loss_count <= sync_loss_count + 32'h1;
					end
					win_cnt <= win_cnt + 7'h01;
					win_err <= (win_cnt == `WIN_LAST) ? 8'h00 : win_err_n;
				end
			end
			if (second_tick) begin
				elapsed_second_count <= elapsed_second_count + 32'h1;
				if (sec_err || err_now || !synced)
					errored_second_count <= errored_second_count +
						32'h1;
				sec_err <= 1'b0;
			end else if (err_now) begin
				sec_err <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			rx_last <= `PAT_OFF;
		else
			rx_last <= rx_pattern_select;
	end

	// Ratio and error free percentage, recomputed continuously
	always @(posedge aclk) begin
		if (!aresetn || restart) begin
			state <= ST_IDLE;
			ratio_mant <= 14'h0000;
			ratio_exp <= 8'h00;
			error_free_second_pct <= `EFS_FULL;
			num <= 48'h0;
			den <= 32'h0;
			pow <= 8'h00;
			rem <= 48'h0;
			dvs <= 48'h0;
			quo <= 14'h0000;
			step <= 4'h0;
			div_efs <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (bit_error_count == 32'h0) begin
					ratio_mant <= 14'h0000;
					ratio_exp <= 8'h00;
					state <= ST_EFS;
				end else begin
					num <= {16'h0000, bit_error_count};
					den <= received_bit_count;
					pow <= 8'h00;
					state <= ST_NORM;
				end
			end
			ST_NORM: begin
				if (num < {16'h0000, den}) begin
					num <= mul_k(num, `TEN);
					pow <= pow + 8'h01;
				end else begin
					rem <= mul_k(num, `MANT_SCALE);
					dvs <= {3'h0, den, 13'h0000};
					quo <= 14'h0000;
					step <= `STEP_LAST;
					div_efs <= 1'b0;
					state <= ST_DIV;
				end
			end
			ST_DIV: begin
				if (q_bit)
					rem <= rem - dvs;
				dvs <= {1'b0, dvs[47:1]};
				quo <= quo_n;
				step <= step - 4'h1;
				if (step == 4'h0) begin
					if (div_efs) begin
						error_free_second_pct <= quo_n;
						state <= ST_IDLE;
					end else begin
						ratio_mant <= quo_n;
						ratio_exp <= pow;
						state <= ST_EFS;
					end
				end
			end
			ST_EFS: begin
				if (errored_second_count == 32'h0 ||
					elapsed_second_count == 32'h0) begin
					error_free_second_pct <= `EFS_FULL;
					state <= ST_IDLE;
				end else begin
					rem <= mul_k({16'h0000, elapsed_second_count -
						errored_second_count}, `EFS_FULL);
					dvs <= {3'h0, elapsed_second_count, 13'h0000};
					quo <= 14'h0000;
					step <= `STEP_LAST;
					div_efs <= 1'b1;
					state <= ST_DIV;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

// *** test/loopback_and_error_rate_tester_test_asserts.sv ***
// Port assertions for the loopback and tester block.
// Bound to the block; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module loopback_and_error_rate_tester_test_asserts (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire ter_in_valid,
	input wire ter_out_valid,
	input wire mod_data,
	input wire mod_valid,
	input wire dem_data,
	input wire dem_valid,
	input wire [7:0] persist_cfg,
	input wire mod_timing_from_demod,
	input wire if_loop_enable
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
property p_bhold;
	s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
endproperty
a_bhold: assert property (p_bhold) else $error("bresp moved");
property p_rhold;
	s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_rhold: assert property (p_rhold) else $error("rdata moved");
property p_ar;
	s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
endproperty
a_ar: assert property (p_ar) else $error("read answer late");
property p_wblock;
	s_axi_bvalid |-> !s_axi_awready;
endproperty
a_wblock: assert property (p_wblock) else $error("write not blocked");
property p_mask;
	persist_cfg[6:5] == 2'h0 && if_loop_enable == persist_cfg[7];
endproperty
a_mask: assert property (p_mask) else $error("stored bits wrong");
property p_sat_mute;
	mod_timing_from_demod && $past(mod_timing_from_demod) |-> !ter_out_valid;
endproperty
a_sat_mute: assert property (p_sat_mute) else $error("ter out live");
property p_sat_echo;
	dem_valid && mod_timing_from_demod |=> !mod_timing_from_demod
		|| (mod_valid && mod_data == $past(dem_data));
endproperty
a_sat_echo: assert property (p_sat_echo) else $error("no echo");
property p_mod_cause;
	mod_valid |-> $past(ter_in_valid) || $past(dem_valid);
endproperty
a_mod_cause: assert property (p_mod_cause) else $error("stray bit");
endmodule
bind loopback_and_error_rate_tester_test loopback_and_error_rate_tester_test_asserts chk_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.ter_in_valid(ter_in_valid), .ter_out_valid(ter_out_valid),
	.mod_data(mod_data), .mod_valid(mod_valid), .dem_data(dem_data),
	.dem_valid(dem_valid), .persist_cfg(persist_cfg),
	.mod_timing_from_demod(mod_timing_from_demod),
	.if_loop_enable(if_loop_enable));

// *** test/link_partner.sv ***
// Far side: terrestrial source and demodulator returning modulator bits.
// One bit every four cycles while run is high; echo loops ter_out back.
`timescale 1ns/1ps
module link_partner (
	input wire aclk,
	input wire run,
	input wire echo,
	input wire mod_data,
	input wire mod_valid,
	input wire ter_out_data,
	input wire ter_out_valid,
	output reg ter_in_data = 1'b0,
	output reg ter_in_valid = 1'b0,
	output reg dem_data = 1'b0,
	output reg dem_valid = 1'b0
);
reg [1:0] ph = 2'h0;
reg [5:0] cnt = 6'h00;
reg mb = 1'b0;
reg tr = 1'b0;
always @(posedge aclk) begin
	ph <= (run || ph != 2'h0) ? ph + 2'h1 : 2'h0;
	if (mod_valid)
		mb <= mod_data;
	if (ter_out_valid)
		tr <= ter_out_data;
	ter_in_valid <= run && ph == 2'h0;
	dem_valid <= ph == 2'h3;
	if (run && ph == 2'h0) begin
		cnt <= cnt + 6'h01;
		ter_in_data <= echo ? tr : cnt[0] ^ cnt[3];
	end else begin
		ter_in_data <= ~ter_in_data;
	end
	dem_data <= ph == 2'h3 ? mb : ~dem_data;
end
endmodule

// *** test/loopback_and_error_rate_tester_test_tb.sv ***
// Register-level tests of the loopback and tester block.
// Assumes the link partner loops modulator bits back to the demodulator.
`timescale 1ns/1ps
`include "loopback_and_error_rate_tester_test_map.vh"
module loopback_and_error_rate_tester_test_tb;
reg aclk = 1'b0;
reg aresetn = 1'b0;
reg [7:0] awaddr = 8'h00, araddr = 8'h00, nv_cfg = 8'h85;
reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
reg rready = 1'b0, tick = 1'b0, run = 1'b0, echo = 1'b0, clr = 1'b0;
reg pat = 1'b0, tin = 1'b0;
reg [31:0] wdata = 32'h0, rv, v0, b0;
reg [22:0] sh;
reg [1:0] rr;
wire awready, wready, bvalid, arready, rvalid, tid, tiv, tod, tov;
wire md, mv, dd, dv, mtd, ifl;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [7:0] pcfg;
integer n_mismatch = 0, num_checks = 0, nb = 0, nm = 0, bad = 0, n0, n;
always #5 aclk = ~aclk;
loopback_and_error_rate_tester_test loopback_and_error_rate_tester_test_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
	.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
	.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
	.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
	.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
	.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
	.ter_in_data(tid), .ter_in_valid(tiv), .ter_out_data(tod),
	.ter_out_valid(tov), .mod_data(md), .mod_valid(mv), .dem_data(dd),
	.dem_valid(dv), .second_tick(tick), .nv_cfg(nv_cfg),
	.persist_cfg(pcfg), .mod_timing_from_demod(mtd),
	.if_loop_enable(ifl));
link_partner link_partner_inst (.aclk(aclk), .run(run), .echo(echo),
	.mod_data(md), .mod_valid(mv), .ter_out_data(tod),
	.ter_out_valid(tov), .ter_in_data(tid), .ter_in_valid(tiv),
	.dem_data(dd), .dem_valid(dv));
// Counts delivered bits and checks the sent pattern's recurrence
always @(posedge aclk) begin
	if (dv)
		nb <= nb + 1;
	if (tiv)
		tin <= tid;
	if (clr) begin
		nm <= 0;
		bad <= 0;
	end else if (mv) begin
		sh <= {sh[21:0], md};
		nm <= nm + 1;
		if (nm > 23 && md !== (pat ? sh[17] ^ sh[22] : sh[8] ^ sh[10]))
			bad <= bad + 1;
	end
end
task chk(input [31:0] g, input [31:0] e);
begin
	num_checks = num_checks + 1;
	if (g !== e) begin
		n_mismatch = n_mismatch + 1;
		$display("MISMATCH %0t got %h want %h", $time, g, e);
	end
end
endtask
task wr(input [7:0] a, input [31:0] d);
begin
	@(posedge aclk);
	awaddr <= a;
	wdata <= d;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	n = 0;
	while (n == 0) begin
		@(posedge aclk);
		if (awready)
			awvalid <= 1'b0;
		if (wready)
			wvalid <= 1'b0;
		if (bvalid)
			n = 1;
	end
	bready <= 1'b0;
	chk(bresp, 0);
end
endtask
task rd(input [7:0] a);
begin
	@(posedge aclk);
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	n = 0;
	while (n == 0) begin
		@(posedge aclk);
		if (arready)
			arvalid <= 1'b0;
		if (rvalid)
			n = 1;
	end
	rready <= 1'b0;
	rv = rdata;
	rr = rresp;
end
endtask
task rc(input [7:0] a, input [31:0] e);
begin
	rd(a);
	chk(rv, e);
end
endtask
task tk;
begin
	@(posedge aclk);
	tick <= 1'b1;
	@(posedge aclk);
	tick <= 1'b0;
end
endtask
task wrap_up;
begin
	$display("checks %0d mismatches %0d", num_checks, n_mismatch);
	if (n_mismatch == 0 && num_checks > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
end
endtask
initial begin
	#200000;
	n_mismatch = n_mismatch + 1;
	wrap_up;
end
initial begin
	repeat (16) @(posedge aclk);
	aresetn <= 1'b1;
	run <= 1'b1;
	repeat (2) @(posedge aclk);
	rc(`A_CTRL, 32'h85);
	chk(ifl, 1);
	chk(pcfg, 8'h85);
	rc(8'h40, 32'h0);
	chk(rr, 2);
	clr <= 1'b1;
	wr(`A_CTRL, 32'h05);
	clr <= 1'b0;
	repeat (400) @(posedge aclk);
	rc(`A_STATUS, 32'h7);
	wr(`A_CMD, 32'h2);
	// Restart drops sync; once resynced, a clean second is not counted as errored
	repeat (400) @(posedge aclk);
	rc(`A_STATUS, 32'h7);
	tk;
	rc(`A_ELAPSED, 32'h1);
	rc(`A_ERR_SEC, 32'h0);
	wr(`A_CMD, 32'h1);
	repeat (200) @(posedge aclk);
	chk(bad, 3);
	rc(`A_BIT_ERR, 32'h1);
	tk;
	rc(`A_ERR_SEC, 32'h1);
	rc(`A_ELAPSED, 32'h2);
	repeat (100) @(posedge aclk);
	rc(`A_EFS_PCT, 32'h1388);
	wr(`A_CMD, 32'h2);
	repeat (100) @(posedge aclk);
	rc(`A_BIT_ERR, 32'h0);
	rc(`A_ERR_SEC, 32'h0);
	rc(`A_ELAPSED, 32'h0);
	rc(`A_RATIO, 32'h0);
	run <= 1'b0;
	repeat (8) @(posedge aclk);
	rd(`A_RX_BITS);
	b0 = rv;
	n0 = nb;
	run <= 1'b1;
	repeat (400) @(posedge aclk);
	run <= 1'b0;
	repeat (8) @(posedge aclk);
	rd(`A_RX_BITS);
	chk(rv - b0, nb - n0);
	run <= 1'b1;
	wr(`A_CTRL, 32'h06);
	repeat (1200) @(posedge aclk);
	rc(`A_SYNC_LOSS, 32'h1);
	rc(`A_STATUS, 32'h6);
	rd(`A_BIT_ERR);
	v0 = rv;
	tk;
	repeat (400) @(posedge aclk);
	rc(`A_BIT_ERR, v0);
	rc(`A_ERR_SEC, 32'h1);
	clr <= 1'b1;
	pat <= 1'b1;
	wr(`A_CTRL, 32'h0a);
	clr <= 1'b0;
	repeat (800) @(posedge aclk);
	rc(`A_STATUS, 32'h7);
	chk(bad, 0);
	echo <= 1'b1;
	wr(`A_CTRL, 32'h15);
	repeat (800) @(posedge aclk);
	rc(`A_STATUS, 32'h7);
	echo <= 1'b0;
	wr(`A_CTRL, 32'h20);
	n = 0;
	while (!tov && n < 20) begin
		@(posedge aclk);
		n = n + 1;
	end
	chk(tov, 1);
	chk(tod, tin);
	wr(`A_CTRL, 32'h40);
	repeat (40) @(posedge aclk);
	chk(mtd, 1);
	wrap_up;
end
endmodule
